// File: src/sbd_dma_engine.sv
/*
  SCSI bus master DMA engine: 24-word FIFO, funnel between the 32-bit host
  bus and the 16-bit SCSI FIFO path, command/status registers and a PIO
  bypass. Assumes a host bus master that takes words on mem_*_valid/ready
  and a SCSI core that keeps its own registers and raises its interrupt.
*/
// Overview of operation
// - 96-byte FIFO of 24 words, width conversion
// - All DMA bytes pass through the FIFO
// - PIO bypasses FIFO, byte on lowest lane
// - Funnel aligns bytes in hardware
// - Transfers organised on 4 KByte pages
// - SCSI moves two bytes per transfer
// - SCSI requests, engine acknowledges each transfer
// - To memory: burst once 16 words present
// - Residue below threshold still forwarded
// - From memory: burst fetch, pass to SCSI
// - Disconnect: keep filling, burst only at threshold
// - Command 01 flushes FIFO to memory
// - Flush completion sets flush complete flag
// - Odd byte pair written, counter zero, done
// - Direction bit 7 selects SCSI to memory
// - Idle command returns idle, no interrupt
// - Two command bits encode four commands
// - Idle stops transfer, keeps status bits
`timescale 1ns/10ps
`default_nettype none
`include "sbd_regs.svh"
module sbd_dma_engine
  import sbd_pkg::*;
(
  input  wire logic          ref_clk,        // PCI clock, 50 MHz
  input  wire logic          reset,          // Synchronous, active high
  input  wire sbd_reg_req_t  reg_req,        // Register access strobe
  output logic [31:0]        reg_rdata,      // Register read data
  input  wire logic [7:0]    scsi_pio_data,  // SCSI register byte (PIO)
  input  wire logic [7:0]    scsi_status,    // SCSI status register
  input  wire logic [7:0]    scsi_fifo_cnt,  // SCSI FIFO count/state
  input  wire logic [23:0]   scsi_xfer_cnt,  // Current transfer count
  input  wire sbd_scsi_req_t scsi_in,        // scsi_side_transfer_request
  output logic               scsi_side_transfer_ack, // Pair taken/given
  output logic [15:0]        scsi_out_data,  // Pair to SCSI FIFO
  output logic               mem_wr_valid,   // Word to memory valid
  input  wire logic          mem_wr_ready,   // Memory takes word
  output logic [31:0]        mem_wr_data,    // Word to memory
  output logic [31:0]        mem_addr,       // Current word address
  output logic               mem_burst_last, // Last word of burst
  input  wire logic          mem_rd_valid,   // Fetched word valid
  output logic               mem_rd_ready,   // Engine takes word
  input  wire logic [31:0]   mem_rd_data,    // Fetched word
  input  wire logic          mem_error,      // Host bus error
  output logic               inta_req        // Interrupt request
);
  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [31:0] fifo_mem [0:`SBD_FIFO_DEPTH-1];
  logic [4:0]  wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic [7:0]  cmd_reg, cmd_next, stat_reg, stat_next;
  logic [23:0] stc_reg, stc_next, wbc_reg, wbc_next;
  logic [31:0] spa_reg, spa_next, wac_reg, wac_next;
  logic [15:0] half_reg, half_next;
  logic        half_vld_reg, half_vld_next;
  logic        hi_sel_reg, hi_sel_next;
  logic [4:0]  burst_reg, burst_next;
  logic [31:0] rdata_next;
  logic [15:0] out_reg, out_next;
  logic        inta_next;
  sbd_state_t  state_reg, state_next;
  logic        push, pop, to_mem, full, empty;
  logic [31:0] push_word;

  function automatic logic [4:0] sbd_inc(input logic [4:0] p);
    sbd_inc = (p == 5'(`SBD_FIFO_DEPTH - 1)) ? 5'h00 : p + 5'h01;
  endfunction : sbd_inc

  assign full     = (cnt_reg == 5'(`SBD_FIFO_DEPTH));
  assign empty    = (cnt_reg == 5'h00);
  assign to_mem   = cmd_reg[`SBD_CMD_DIR];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    wptr_next = wptr_reg;  rptr_next = rptr_reg;  cnt_next = cnt_reg;
    cmd_next = cmd_reg;  stat_next = stat_reg;  stc_next = stc_reg;
    wbc_next = wbc_reg;  spa_next = spa_reg;  wac_next = wac_reg;
    half_next = half_reg;  half_vld_next = half_vld_reg;
    hi_sel_next = hi_sel_reg;  burst_next = burst_reg;
    out_next = out_reg;
    state_next = state_reg;  push = 1'b0;  pop = 1'b0;
    push_word = mem_rd_data;
    scsi_side_transfer_ack = 1'b0;
    mem_wr_valid = 1'b0;  mem_rd_ready = 1'b0;  mem_burst_last = 1'b0;
    // SCSI side: one pair per request, funnelled into words.
    if (state_reg != SBD_ST_IDLE && to_mem && scsi_in.req &&
        !(half_vld_reg && full)) begin
      scsi_side_transfer_ack = 1'b1;
      if (half_vld_reg) begin
        push = 1'b1;
        push_word = {scsi_in.data, half_reg};
        half_vld_next = 1'b0;
      end else if (scsi_in.last_odd) begin
        push = !full;
        push_word = {16'h0000, scsi_in.data};
        scsi_side_transfer_ack = !full;
      end else begin
        half_next = scsi_in.data;
        half_vld_next = 1'b1;
      end
    end
    // Memory side, SCSI to memory: burst at threshold or on flush.
    if (state_reg != SBD_ST_IDLE && to_mem && !empty &&
        (burst_reg != 5'h00 || cnt_reg >= 5'(`SBD_BURST_WORDS) ||
         state_reg == SBD_ST_FLUSH || wbc_reg <= 24'(cnt_reg) * 24'd4))
    begin
      mem_wr_valid = 1'b1;
      mem_burst_last = (burst_reg == 5'(`SBD_BURST_WORDS - 1)) ||
                       (cnt_reg == 5'h01) ||
                       ((wac_reg & `SBD_PAGE_MASK) == 32'h0000_0FFC);
      if (mem_wr_ready) begin
        pop = 1'b1;
        burst_next = mem_burst_last ? 5'h00 : burst_reg + 5'h01;
        wac_next = wac_reg + 32'h0000_0004;
        wbc_next = (wbc_reg > 24'd4) ? wbc_reg - 24'd4 : 24'h000000;
      end
    end
    // Memory to SCSI: fetch words, hand them out as pairs.
    if (state_reg == SBD_ST_RUN && !to_mem) begin
      mem_rd_ready = !full && wbc_reg > 24'(cnt_reg) * 24'd4;
      if (mem_rd_valid && mem_rd_ready) begin
        push = 1'b1;
        wac_next = wac_reg + 32'h0000_0004;
      end
      if (scsi_in.req && !empty) begin
        scsi_side_transfer_ack = 1'b1;
        out_next = hi_sel_reg ? fifo_mem[rptr_reg][31:16]
                              : fifo_mem[rptr_reg][15:0];
        hi_sel_next = !hi_sel_reg;
        pop = hi_sel_reg;
        wbc_next = (wbc_reg > 24'd2) ? wbc_reg - 24'd2 : 24'h000000;
      end
    end
    if (push) wptr_next = sbd_inc(wptr_reg);
    if (pop)  rptr_next = sbd_inc(rptr_reg);
    cnt_next = cnt_reg + 5'(push) - 5'(pop);
    // Completion events: transfer done and flush complete.
    if (state_reg != SBD_ST_IDLE && wbc_next == 24'h000000 &&
        cnt_next == 5'h00 && !half_vld_next) begin
      stat_next[`SBD_ST_DONE] = 1'b1;
      if (state_reg == SBD_ST_FLUSH)
        stat_next[`SBD_ST_FLUSH_COMPLETE_FLAG] = 1'b1;
      state_next = SBD_ST_IDLE;
    end
    if (state_reg == SBD_ST_FLUSH && cnt_next == 5'h00) begin
      stat_next[`SBD_ST_FLUSH_COMPLETE_FLAG] = 1'b1;
      state_next = SBD_ST_IDLE;
    end
    // Register writes: the command code acts on each write.
    if (reg_req.wr) begin
      case (reg_req.addr)
        `SBD_OFF_CMD: begin
          cmd_next = reg_req.wdata[7:0] & 8'hF3;
          case (sbd_cmd_t'(reg_req.wdata[1:0]))
            SBD_CMD_IDLE:  state_next = SBD_ST_IDLE;
            SBD_CMD_FLUSH: state_next = SBD_ST_FLUSH;
            SBD_CMD_ABORT: begin
              state_next = SBD_ST_IDLE;
              stat_next[`SBD_ST_ABORT] = 1'b1;
            end
            SBD_CMD_START: begin
              state_next = SBD_ST_RUN;
              stat_next = 8'h00;
              wbc_next = stc_reg;
              wac_next = spa_reg;
              cnt_next = 5'h00;  wptr_next = 5'h00;  rptr_next = 5'h00;
              half_vld_next = 1'b0;  hi_sel_next = 1'b0;
              burst_next = 5'h00;
            end
            default: state_next = SBD_ST_IDLE;
          endcase
        end
        `SBD_OFF_STC: stc_next = reg_req.wdata[23:0];
        `SBD_OFF_SPA: spa_next = reg_req.wdata;
        default: ;
      endcase
    end
    // Set wins: a bus error in the cycle of a START still shows.
    if (mem_error) stat_next[`SBD_ST_ERROR] = 1'b1;
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (reg_req.addr)
      `SBD_OFF_CNT_LO:  rdata_next = {24'h000000, scsi_xfer_cnt[7:0]};
      `SBD_OFF_CNT_MID: rdata_next = {24'h000000, scsi_xfer_cnt[15:8]};
      `SBD_OFF_CNT_HI:  rdata_next = {24'h000000, scsi_xfer_cnt[23:16]};
      `SBD_OFF_SSTAT:   rdata_next = {24'h000000, scsi_status};
      `SBD_OFF_SFIFO:   rdata_next = {24'h000000, scsi_fifo_cnt};
      `SBD_OFF_CMD:     rdata_next = {24'h000000, cmd_reg};
      `SBD_OFF_STC:     rdata_next = {8'h00, stc_reg};
      `SBD_OFF_SPA:     rdata_next = spa_reg;
      `SBD_OFF_WBC:     rdata_next = {8'h00, wbc_reg};
      `SBD_OFF_WAC:     rdata_next = wac_reg;
      `SBD_OFF_STAT:    rdata_next = {24'h000000, stat_reg};
      // Any other SCSI register is PIO: one byte, upper lanes null.
      default:          rdata_next = {24'h000000, scsi_pio_data};
    endcase
    // Idle raises nothing; only error/done with the enable bit set do.
    inta_next = cmd_reg[`SBD_CMD_INTE_D] &&
                (stat_reg[`SBD_ST_DONE] || stat_reg[`SBD_ST_ERROR]);
  end

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (push) fifo_mem[wptr_reg] <= push_word;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wptr_reg <= 5'h00;  rptr_reg <= 5'h00;  cnt_reg <= 5'h00;
      cmd_reg <= 8'h00;  stat_reg <= 8'h00;  stc_reg <= 24'h000000;
      wbc_reg <= 24'h000000;  spa_reg <= `SBD_RESET_WORD;
      wac_reg <= `SBD_RESET_WORD;  half_reg <= 16'h0000;
      half_vld_reg <= 1'b0;  hi_sel_reg <= 1'b0;  burst_reg <= 5'h00;
      out_reg <= 16'h0000;
      reg_rdata <= `SBD_RESET_WORD;  inta_req <= 1'b0;
      state_reg <= SBD_ST_IDLE;
    end else begin
      wptr_reg <= wptr_next;  rptr_reg <= rptr_next;  cnt_reg <= cnt_next;
      cmd_reg <= cmd_next;  stat_reg <= stat_next;  stc_reg <= stc_next;
      wbc_reg <= wbc_next;  spa_reg <= spa_next;  wac_reg <= wac_next;
      half_reg <= half_next;  half_vld_reg <= half_vld_next;
      hi_sel_reg <= hi_sel_next;  burst_reg <= burst_next;
      out_reg <= out_next;
      reg_rdata <= rdata_next;  inta_req <= inta_next;
      state_reg <= state_next;
    end
  end

  // Write data is read straight from the FIFO head so it matches valid.
  always_comb begin
    mem_wr_data   = fifo_mem[rptr_reg];
    mem_addr      = wac_reg;
    scsi_out_data = out_reg;
  end
endmodule : sbd_dma_engine
`default_nettype wire

// File: src/sbd_regs.svh
/*
  Offsets, field positions, reset values and counts for the SCSI bus
  master DMA engine. Assumes byte addresses on the register port.
*/
`ifndef SBD_REGS_SVH
`define SBD_REGS_SVH
`define SBD_OFF_CNT_LO   8'h00
`define SBD_OFF_CNT_MID  8'h04
`define SBD_OFF_SSTAT    8'h10
`define SBD_OFF_SFIFO    8'h1C
`define SBD_OFF_CNT_HI   8'h38
`define SBD_OFF_CMD      8'h40
`define SBD_OFF_STC      8'h44
`define SBD_OFF_SPA      8'h48
`define SBD_OFF_WBC      8'h4C
`define SBD_OFF_WAC      8'h50
`define SBD_OFF_STAT     8'h54
`define SBD_CMD_DIR      7
`define SBD_CMD_INTE_D   6
`define SBD_ST_ABORT     2
`define SBD_ST_FLUSH_COMPLETE_FLAG    5
`define SBD_ST_DONE      4
`define SBD_ST_ERROR     1
`define SBD_FIFO_DEPTH   24
`define SBD_BURST_WORDS  16
`define SBD_PAGE_MASK    32'h0000_0FFF
`define SBD_RESET_WORD   32'h0000_0000
`endif

// File: src/sbd_pkg.sv
/*
  Types shared by the DMA engine. Assumes sbd_regs.svh is compiled too.
*/
package sbd_pkg;
  typedef enum logic [1:0] {
    SBD_CMD_IDLE  = 2'b00,
    SBD_CMD_FLUSH = 2'b01,
    SBD_CMD_ABORT = 2'b10,
    SBD_CMD_START = 2'b11
  } sbd_cmd_t;
  typedef enum logic [1:0] {
    SBD_ST_IDLE  = 2'b00,
    SBD_ST_RUN   = 2'b01,
    SBD_ST_FLUSH = 2'b10
  } sbd_state_t;
  typedef struct packed {
    logic        req;
    logic [15:0] data;
    logic        last_odd;
  } sbd_scsi_req_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } sbd_reg_req_t;
endpackage : sbd_pkg

// File: verification/sbd_dma_engine_checker.sv
/*
  Port checker for sbd_dma_engine, bound into every instance.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sbd_regs.svh"
module sbd_dma_engine_checker
  import sbd_pkg::*;
(
  input wire logic          ref_clk,                // Clock
  input wire logic          reset,                  // Reset
  input wire sbd_reg_req_t  reg_req,                // Register strobe
  input wire logic [31:0]   reg_rdata,              // Read data
  input wire logic [7:0]    scsi_pio_data,          // PIO byte
  input wire logic [23:0]   scsi_xfer_cnt,          // Transfer count
  input wire sbd_scsi_req_t scsi_in,                // SCSI request
  input wire logic          scsi_side_transfer_ack, // SCSI ack
  input wire logic          mem_wr_valid,           // Write valid
  input wire logic          mem_wr_ready,           // Write ready
  input wire logic [31:0]   mem_wr_data,            // Write word
  input wire logic [31:0]   mem_addr,               // Word address
  input wire logic          mem_burst_last,         // Burst end
  input wire logic          mem_rd_ready,           // Read ready
  input wire logic          inta_req                // Interrupt
);
  logic inte_reg, inte_next, dir_reg, dir_next;
  wire  cmd_wr = reg_req.wr && reg_req.addr == `SBD_OFF_CMD;
  always_comb begin
    inte_next = cmd_wr ? reg_req.wdata[6] : inte_reg;
    dir_next  = cmd_wr ? reg_req.wdata[7] : dir_reg;
  end
  always_ff @(posedge ref_clk) begin
    inte_reg <= reset ? 1'b0 : inte_next;
    dir_reg  <= reset ? 1'b0 : dir_next;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_ack_needs_req: assert property (
    scsi_side_transfer_ack |-> scsi_in.req) else $error("ack without req");
  a_wr_held: assert property (mem_wr_valid && !mem_wr_ready |=>
    mem_wr_valid && $stable(mem_wr_data) && $stable(mem_addr))
    else $error("write offer dropped");
  a_addr_step: assert property (mem_wr_valid && mem_wr_ready |=>
    mem_addr == $past(mem_addr) + 32'h4) else $error("address step");
  a_page_last: assert property (
    mem_wr_valid && mem_addr[11:2] == 10'h3FF |-> mem_burst_last)
    else $error("burst crosses page");
  a_pio_lane: assert property ($past(reg_req.addr) == 8'h60 |->
    reg_rdata == {24'h0, $past(scsi_pio_data)}) else $error("pio lane");
  a_count_low: assert property ($past(reg_req.addr) == 8'h00 |->
    reg_rdata == {24'h0, $past(scsi_xfer_cnt[7:0])}) else $error("cnt lo");
  a_count_high: assert property ($past(reg_req.addr) == 8'h38 |->
    reg_rdata == {24'h0, $past(scsi_xfer_cnt[23:16])}) else $error("cnt hi");
  a_inta_gated: assert property (!inte_reg && !$past(inte_reg) |->
    !inta_req) else $error("interrupt while disabled");
  a_dir_gate: assert property ((dir_reg |-> !mem_rd_ready) and
    (!dir_reg |-> !mem_wr_valid)) else $error("wrong direction");
  c_ack: cover property (scsi_side_transfer_ack);
  c_last: cover property (mem_wr_valid && mem_burst_last);
  c_irq: cover property ($rose(inta_req));
endmodule : sbd_dma_engine_checker
bind sbd_dma_engine sbd_dma_engine_checker u_chk (.ref_clk(ref_clk),
  .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .scsi_pio_data(scsi_pio_data), .scsi_xfer_cnt(scsi_xfer_cnt),
  .scsi_in(scsi_in), .scsi_side_transfer_ack(scsi_side_transfer_ack),
  .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
  .mem_wr_data(mem_wr_data), .mem_addr(mem_addr),
  .mem_burst_last(mem_burst_last), .mem_rd_ready(mem_rd_ready),
  .inta_req(inta_req));
`default_nettype wire

// File: verification/sbd_mem_model.sv
/*
  Host memory partner: records written words with addresses and serves
  a counter pattern on reads. Assumes stall changes after the clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module sbd_mem_model (
  input  wire logic        ref_clk,      // Clock
  input  wire logic        reset,        // Reset
  input  wire logic        stall,        // Holds write ready and new read offers off
  input  wire logic        mem_wr_valid, // Word offered
  output logic             mem_wr_ready, // Word taken
  input  wire logic [31:0] mem_wr_data,  // Offered word
  input  wire logic [31:0] mem_addr,     // Word address
  output logic             mem_rd_valid, // Read word offered
  input  wire logic        mem_rd_ready, // Read word taken
  output logic [31:0]      mem_rd_data,  // Read word
  output logic             mem_error     // Never raised
);
  logic [31:0] wq[$], aq[$];
  logic [31:0] n, word;
  assign word = 32'hC3A5_5A3C ^ (n * 32'h0101_0101);
  assign mem_wr_ready = ~stall;
  // Data is inverted while not offered so stale values never match.
  assign mem_rd_data = mem_rd_valid ? word : ~word;
  assign mem_error = 1'b0;
  always @(posedge ref_clk) begin
    if (reset) begin
      mem_rd_valid <= 1'b0;
      n <= 32'h0;
    end else if (mem_rd_valid && mem_rd_ready) begin
      mem_rd_valid <= 1'b0;
      n <= n + 32'h1;
    end else if (!stall) mem_rd_valid <= 1'b1;
    if (!reset && mem_wr_valid && mem_wr_ready) begin
      wq.push_back(mem_wr_data);
      aq.push_back(mem_addr);
    end
  end
endmodule : sbd_mem_model
`default_nettype wire

// File: verification/sbd_dma_engine_bench.sv
/*
  Bench for sbd_dma_engine: register reads, bursts over a page end,
  disconnect with flush, abort, memory to SCSI. Assumes sbd_mem_model.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sbd_regs.svh"
module sbd_dma_engine_bench;
  import sbd_pkg::*;
  logic          ref_clk = 1'b0, reset = 1'b1, stall = 1'b0;
  sbd_reg_req_t  reg_req = '0;
  sbd_scsi_req_t scsi_in = '0;
  logic [7:0]    pio = 8'h00, sst = 8'h00, sfc = 8'h00;
  logic [23:0]   xc = 24'h0;
  logic [31:0]   rdata, wd, ma, mrd, lo;
  logic          ack, wv, wr, bl, rv, rr, me, inta;
  logic [15:0]   sout;
  integer        seed = 32'hd43c, n_fail = 0, samples_checked = 0;
  integer        cyc = 0, i, k;
  logic [31:0]   exp_q[$];
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) #1 stall = ($random(seed) & 3) == 0;
  sbd_dma_engine DUT (.ref_clk(ref_clk), .reset(reset), .reg_req(reg_req),
    .reg_rdata(rdata), .scsi_pio_data(pio), .scsi_status(sst),
    .scsi_fifo_cnt(sfc), .scsi_xfer_cnt(xc), .scsi_in(scsi_in),
    .scsi_side_transfer_ack(ack), .scsi_out_data(sout),
    .mem_wr_valid(wv), .mem_wr_ready(wr), .mem_wr_data(wd), .mem_addr(ma),
    .mem_burst_last(bl), .mem_rd_valid(rv), .mem_rd_ready(rr),
    .mem_rd_data(mrd), .mem_error(me), .inta_req(inta));
  sbd_mem_model mem (.ref_clk(ref_clk), .reset(reset), .stall(stall),
    .mem_wr_valid(wv), .mem_wr_ready(wr), .mem_wr_data(wd), .mem_addr(ma),
    .mem_rd_valid(rv), .mem_rd_ready(rr), .mem_rd_data(mrd),
    .mem_error(me));
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic wrap_up;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick;
    reg_req.wr = 1'b0;
    tick;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    reg_req.addr = a;
    tick;
    check(rdata, e);
  endtask : rreg
  // Request is held until the edge that samples ack high.
  task automatic push(input logic [15:0] d, input logic o);
    scsi_in = '{req: 1'b1, data: d, last_odd: o};
    do @(negedge ref_clk); while (ack !== 1'b1);
    tick;
  endtask : push
  task automatic feed(input integer n, input logic odd);
    for (i = 0; i < n; i++) begin
      k = $random(seed);
      push(k[15:0], 1'b0);
      if (i % 2 == 0) lo = k;
      else exp_q.push_back({k[15:0], lo[15:0]});
    end
    if (odd) begin
      k = $random(seed);
      push(k[15:0], 1'b1);
      exp_q.push_back({16'h0, k[15:0]});
    end
    scsi_in.req = 1'b0;
  endtask : feed
  task automatic drain(input logic [31:0] a0);
    for (k = 0; k < 2000 && mem.wq.size() < exp_q.size(); k++) tick;
    repeat (3) tick;
    check(32'(mem.wq.size()), 32'(exp_q.size()));
    for (i = 0; i < exp_q.size(); i++) begin
      check(mem.wq[i], exp_q[i]);
      check(mem.aq[i], a0 + 32'(4 * i));
    end
    mem.wq.delete();
    mem.aq.delete();
    exp_q.delete();
  endtask : drain
  initial begin
    repeat (10) tick;
    reset = 1'b0;
    for (i = 0; i < 4; i++) begin
      {pio, sst, sfc} = $random(seed);
      xc = $random(seed);
      rreg(`SBD_OFF_CNT_LO, {24'h0, xc[7:0]});
      rreg(`SBD_OFF_CNT_MID, {24'h0, xc[15:8]});
      rreg(`SBD_OFF_CNT_HI, {24'h0, xc[23:16]});
      rreg(`SBD_OFF_SSTAT, {24'h0, sst});
      rreg(`SBD_OFF_SFIFO, {24'h0, sfc});
      rreg(8'h60, {24'h0, pio});
    end
    wreg(`SBD_OFF_STC, 32'd70);
    wreg(`SBD_OFF_SPA, 32'h0000_0FF8);
    wreg(`SBD_OFF_CMD, 32'hC3);
    feed(34, 1'b1);
    drain(32'h0000_0FF8);
    rreg(`SBD_OFF_STAT, 32'h10);
    rreg(`SBD_OFF_WBC, 32'h0);
    check({31'h0, inta}, 32'h1);
    wreg(`SBD_OFF_STC, 32'd200);
    wreg(`SBD_OFF_SPA, 32'h0000_2000);
    wreg(`SBD_OFF_CMD, 32'h83);
    feed(10, 1'b0);
    repeat (30) tick;
    check(32'(mem.wq.size()), 32'h0);
    rreg(`SBD_OFF_STAT, 32'h0);
    wreg(`SBD_OFF_CMD, 32'h81);
    reg_req.addr = `SBD_OFF_STAT;
    for (k = 0; k < 500 && rdata[5] !== 1'b1; k++) tick;
    drain(32'h0000_2000);
    rreg(`SBD_OFF_STAT, 32'h20);
    wreg(`SBD_OFF_CMD, 32'h80);
    rreg(`SBD_OFF_STAT, 32'h20);
    check({31'h0, inta}, 32'h0);
    wreg(`SBD_OFF_CMD, 32'h83);
    wreg(`SBD_OFF_CMD, 32'h82);
    rreg(`SBD_OFF_STAT, 32'h04);
    wreg(`SBD_OFF_STC, 32'd16);
    wreg(`SBD_OFF_SPA, 32'h0000_3000);
    wreg(`SBD_OFF_CMD, 32'h03);
    for (i = 0; i < 8; i++) begin
      push(16'h0, 1'b0);
      k = 32'hC3A5_5A3C ^ ((i / 2) * 32'h0101_0101);
      check({16'h0, sout}, {16'h0, i % 2 ? k[31:16] : k[15:0]});
    end
    scsi_in.req = 1'b0;
    wrap_up;
  end
endmodule : sbd_dma_engine_bench
`default_nettype wire
